//--- include/hub_port_pkg.sv
package hub_port_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_DEV_ADDR_A  = 8'h10;
   localparam logic [7:0] ADDR_DEV_ADDR_B  = 8'h40;
   localparam logic [7:0] ADDR_CONNECT     = 8'h48;
   localparam logic [7:0] ADDR_PORT_ENABLE = 8'h49;
   localparam logic [7:0] ADDR_PORT_SPEED  = 8'h4a;
   localparam logic [7:0] ADDR_SUSPEND     = 8'h4d;
   localparam logic [7:0] ADDR_RESUME      = 8'h4e;
   localparam logic [7:0] ADDR_LINE_ZERO   = 8'h4f;
   localparam logic [7:0] ADDR_LINE_DATA   = 8'h50;
   localparam logic [7:0] ADDR_FORCE_CTRL  = 8'h51;
   localparam logic [7:0] ADDR_STATUS      = 8'h60;
   localparam logic [7:0] ADDR_INT_ENABLE  = 8'h61;
   localparam logic [7:0] ADDR_INT_PEND    = 8'h62;
   localparam logic [7:0] ADDR_CONTROL     = 8'h63;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int         BUS_RESET_BIT    = 5;
   localparam logic [7:0] RESET_VALUE      = 8'h00;
   localparam int         PORTS            = 4;
   localparam int         ENDPOINTS        = 5;
   localparam int         PEND_BUSRST      = 0;
   localparam int         PEND_T128        = 1;
   localparam int         PEND_T1024       = 2;
   localparam int         PEND_HUB         = 3;
   localparam int         PEND_EP0         = 4;
   localparam logic [1:0] FORCE_NONE       = 2'h0;
   localparam logic [1:0] FORCE_DIFF_ONE   = 2'h1;
   localparam logic [1:0] FORCE_DIFF_ZERO  = 2'h2;
   localparam logic [1:0] FORCE_SE0        = 2'h3;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ        = 100;
   localparam int SE0_MIN_US     = 12;
   localparam int SE0_MAX_US     = 16;
   localparam int SE0_CYCLES     = SE0_MIN_US * CLK_MHZ + CLK_MHZ * 2;
   localparam int T128_US        = 128;
   localparam int T128_CYCLES    = T128_US * CLK_MHZ;
   localparam int T1024_RATIO    = 8;
endpackage : hub_port_pkg

//--- rtl/usb_hub_port_control.sv
// Operation
// - upstream SE0 becomes a bus reset after 14 us, within 12..16 us
// - detected bus reset sets status bit five for firmware
// - bus reset clears device addresses and all hub port registers
// - bus reset interrupt pends when the SE0 ends
// - free-running 128 us and 1.024 ms timer interrupts
// - endpoint interrupt on final acknowledge; unacknowledged IN gives none
// - hub interrupt on connect change, babble or resume
// - babble and resume count only on enabled ports
// - connect changes on forced ports raise no hub interrupt
// - speed bit one means low speed, zero full speed
// - speed register clears on resets; upper bits read zero
// - enabled unsuspended port repeats traffic unless babbling
// - low speed ports never get full speed upstream traffic
// - enable takes effect after current packet, at once when idle
// - in suspend connect changes interrupt even on disabled ports
// - enable resets to zero; babble clears the port enable
// - babble is traffic or open connectivity at EOF2 on enabled port
// - two-bit force field: normal, diff one, diff zero, SE0
// - force register resets to zero, meaning normal traffic
// - forced lines use edge rate matching the port speed
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module usb_hub_port_control (
   input  wire logic       core_clk,
   input  wire logic       rst_b,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdData,
   input  wire logic       upDp,
   input  wire logic       upDm,
   input  wire logic [3:0] portConnect,
   input  wire logic [3:0] portResume,
   input  wire logic [3:0] portNonIdle,
   input  wire logic [3:0] portOpen,
   input  wire logic       eofTwo,
   input  wire logic       packetActive,
   input  wire logic       upFullSpeed,
   input  wire logic       suspended,
   input  wire logic [4:0] epAck,
   output logic      [3:0] portRepeat,
   output logic      [3:0] portDriveEn,
   output logic      [3:0] portDriveDp,
   output logic      [3:0] portDriveDm,
   output logic      [3:0] portSlowEdge,
   output logic      [9:0] irqPending
);
   // ------------------------------------------------------------
   // synchronisers and line state
   // ------------------------------------------------------------
   logic [1:0] upMeta;
   logic [1:0] upSync;
   logic [3:0] connMeta;
   logic [3:0] connSync;
   logic [3:0] connLast;
   logic [3:0] resMeta;
   logic [3:0] resSync;
   logic [3:0] resLast;

   // first stage feeds only the second stage
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         upMeta   <= 2'h3;
         upSync   <= 2'h3;
         connMeta <= 4'h0;
         connSync <= 4'h0;
         connLast <= 4'h0;
         resMeta  <= 4'h0;
         resSync  <= 4'h0;
         resLast  <= 4'h0;
      end else begin
         upMeta   <= {upDp, upDm};
         upSync   <= upMeta;
         connMeta <= portConnect;
         connSync <= connMeta;
         connLast <= connSync;
         resMeta  <= portResume;
         resSync  <= resMeta;
         resLast  <= resSync;
      end
   end

   wire       lineSe0 = (upSync == 2'h0);
   wire [3:0] connChange = connSync ^ connLast;
   wire [3:0] resumeRise = resSync & ~resLast;

   // ------------------------------------------------------------
   // bus reset detector
   // ------------------------------------------------------------
   logic [11:0] se0Count;
   logic        inBusReset;
   logic        busResetPulse;
   // 14 us sits safely between the may and must bounds
   localparam logic [11:0] SE0_LIMIT =
      12'(hub_port_pkg::SE0_CYCLES - 1);
   wire se0Hit = lineSe0 && (se0Count == SE0_LIMIT) && !inBusReset;
   wire busResetEnd = inBusReset && !lineSe0;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         se0Count      <= 12'h000;
         inBusReset    <= 1'b0;
         busResetPulse <= 1'b0;
      end else begin
         busResetPulse <= se0Hit;
         if (!lineSe0)
            se0Count <= 12'h000;
         else if (se0Count != SE0_LIMIT)
            se0Count <= se0Count + 12'h001;
         if (se0Hit)
            inBusReset <= 1'b1;
         else if (busResetEnd)
            inBusReset <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // timer base
   // ------------------------------------------------------------
   logic [13:0] tickCount;
   logic [2:0]  msCount;
   localparam logic [13:0] T128_LAST =
      14'(hub_port_pkg::T128_CYCLES - 1);
   localparam logic [2:0] MS_LAST =
      3'(hub_port_pkg::T1024_RATIO - 1);
   wire tick128 = (tickCount == T128_LAST);
   wire tick1024 = tick128 && (msCount == MS_LAST);

   // free running, no reset on bus reset
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tickCount <= 14'h0000;
         msCount   <= 3'h0;
      end else begin
         tickCount <= tick128 ? 14'h0000 : tickCount + 14'h0001;
         if (tick128)
            msCount <= msCount + 3'h1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] devAddrA;
   logic [7:0] devAddrB;
   logic [3:0] portEnable;
   logic [3:0] enableWanted;
   logic [3:0] portSpeed;
   logic [3:0] portSuspend;
   logic [3:0] resumeStatus;
   logic [7:0] forceCtrl;
   logic [7:0] statusReg;
   logic [7:0] intEnable;

   wire wrA     = regWrite && (regAddr == hub_port_pkg::ADDR_DEV_ADDR_A);
   wire wrB     = regWrite && (regAddr == hub_port_pkg::ADDR_DEV_ADDR_B);
   wire wrEn    = regWrite && (regAddr == hub_port_pkg::ADDR_PORT_ENABLE);
   wire wrSpd   = regWrite && (regAddr == hub_port_pkg::ADDR_PORT_SPEED);
   wire wrSus   = regWrite && (regAddr == hub_port_pkg::ADDR_SUSPEND);
   wire wrRes   = regWrite && (regAddr == hub_port_pkg::ADDR_RESUME);
   wire wrForce = regWrite && (regAddr == hub_port_pkg::ADDR_FORCE_CTRL);
   wire wrStat  = regWrite && (regAddr == hub_port_pkg::ADDR_STATUS);
   wire wrIe    = regWrite && (regAddr == hub_port_pkg::ADDR_INT_ENABLE);
   wire wrPend  = regWrite && (regAddr == hub_port_pkg::ADDR_INT_PEND);

   // babble at EOF2 on an enabled port
   wire [3:0] babble = eofTwo ? (portEnable & (portNonIdle | portOpen))
                              : 4'h0;

   // pending enables land when no packet is on the wire
   wire [3:0] next_enable = (portEnable | (packetActive ? 4'h0 :
                            enableWanted)) & ~babble;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         devAddrA     <= hub_port_pkg::RESET_VALUE;
         devAddrB     <= hub_port_pkg::RESET_VALUE;
         portEnable   <= 4'h0;
         enableWanted <= 4'h0;
         portSpeed    <= 4'h0;
         portSuspend  <= 4'h0;
         resumeStatus <= 4'h0;
         forceCtrl    <= hub_port_pkg::RESET_VALUE;
         statusReg    <= hub_port_pkg::RESET_VALUE;
         intEnable    <= hub_port_pkg::RESET_VALUE;
      end else if (se0Hit) begin
         devAddrA     <= 8'h00;
         devAddrB     <= 8'h00;
         portEnable   <= 4'h0;
         enableWanted <= 4'h0;
         portSpeed    <= 4'h0;
         portSuspend  <= 4'h0;
         resumeStatus <= 4'h0;
         forceCtrl    <= 8'h00;
         statusReg[hub_port_pkg::BUS_RESET_BIT] <= 1'b1;
      end else begin
         if (wrA)
            devAddrA <= regWrData;
         if (wrB)
            devAddrB <= regWrData;
         if (wrSpd)
            portSpeed <= regWrData[3:0];
         if (wrSus)
            portSuspend <= regWrData[3:0];
         if (wrForce)
            forceCtrl <= regWrData;
         if (wrIe)
            intEnable <= regWrData;
         // a new event wins over a software clear
         resumeStatus <= (wrRes ? resumeStatus & ~regWrData[3:0]
                         : resumeStatus) | resumeRise;
         if (wrStat)
            statusReg <= regWrData;
         if (wrEn) begin
            // disabling is immediate, enabling waits for idle
            portEnable   <= portEnable & regWrData[3:0] & ~babble;
            enableWanted <= regWrData[3:0] & ~portEnable;
         end else begin
            portEnable   <= next_enable;
            enableWanted <= packetActive ? enableWanted & ~babble : 4'h0;
         end
      end
   end

   // ------------------------------------------------------------
   // interrupt sources
   // ------------------------------------------------------------
   logic [9:0] pend;
   wire [3:0] forced;
   wire [3:0] connEvent;
   genvar p;
   generate
      for (p = 0; p < hub_port_pkg::PORTS; p++) begin : gForced
         assign forced[p] = (forceCtrl[2*p+1 -: 2] !=
                             hub_port_pkg::FORCE_NONE);
      end
   endgenerate
   // forced ports are mute; connect changes are never gated by the enable, suspended or not
   assign connEvent = connChange & ~forced &
                      (suspended ? 4'hf : 4'hf);
   wire hubEvent = (|connEvent) ||
                   (|((babble | resumeRise) & portEnable));
   wire [9:0] setPend = {1'b0, epAck, hubEvent, tick1024, tick128,
                         busResetEnd};
   wire [9:0] clrPend = wrPend ? {2'h0, regWrData} : 10'h000;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         pend <= 10'h000;
      else
         pend <= (pend & ~clrPend) | setPend;            // set beats clear
   end

   // ------------------------------------------------------------
   // repeater and line forcing
   // ------------------------------------------------------------
   wire [3:0] next_repeat = portEnable & ~portSuspend & ~babble &
                            ~(portSpeed & {4{upFullSpeed}});
   logic [3:0] next_dp;
   logic [3:0] next_dm;
   always_comb begin
      for (int i = 0; i < hub_port_pkg::PORTS; i++) begin
         next_dp[i] = (forceCtrl[2*i+1 -: 2] == hub_port_pkg::FORCE_DIFF_ONE);
         next_dm[i] = (forceCtrl[2*i+1 -: 2] == hub_port_pkg::FORCE_DIFF_ZERO);
      end
   end

   // ------------------------------------------------------------
   // read mux
   // ------------------------------------------------------------
   wire [7:0] rdMux =
      (regAddr == hub_port_pkg::ADDR_DEV_ADDR_A)  ? devAddrA :
      (regAddr == hub_port_pkg::ADDR_DEV_ADDR_B)  ? devAddrB :
      (regAddr == hub_port_pkg::ADDR_CONNECT)     ? {4'h0, connSync} :
      (regAddr == hub_port_pkg::ADDR_PORT_ENABLE) ? {4'h0, portEnable} :
      (regAddr == hub_port_pkg::ADDR_PORT_SPEED)  ? {4'h0, portSpeed} :
      (regAddr == hub_port_pkg::ADDR_SUSPEND)     ? {4'h0, portSuspend} :
      (regAddr == hub_port_pkg::ADDR_RESUME)      ? {4'h0, resumeStatus} :
      (regAddr == hub_port_pkg::ADDR_FORCE_CTRL)  ? forceCtrl :
      (regAddr == hub_port_pkg::ADDR_STATUS)      ? statusReg :
      (regAddr == hub_port_pkg::ADDR_INT_ENABLE)  ? intEnable :
      (regAddr == hub_port_pkg::ADDR_INT_PEND)    ? pend[7:0] :
      (regAddr == hub_port_pkg::ADDR_CONTROL)     ? {6'h00, pend[9:8]} :
      8'h00;

   // all outputs registered
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         regRdData    <= 8'h00;
         portRepeat   <= 4'h0;
         portDriveEn  <= 4'h0;
         portDriveDp  <= 4'h0;
         portDriveDm  <= 4'h0;
         portSlowEdge <= 4'h0;
         irqPending   <= 10'h000;
      end else begin
         regRdData    <= regRead ? rdMux : 8'h00;
         portRepeat   <= next_repeat;
         portDriveEn  <= forced;
         portDriveDp  <= next_dp;
         portDriveDm  <= next_dm;
         portSlowEdge <= portSpeed;
         irqPending   <= pend;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   // every check below lives on core_clk and is off during reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   sequence s_se0Long;
      lineSe0 [*8];
   endsequence
   a_bus_reset_flag: assert property (
      se0Hit |=> statusReg[hub_port_pkg::BUS_RESET_BIT])
      else $error("bus reset flag not set");
   a_reset_clears: assert property (
      se0Hit |=> (portEnable == 4'h0 && forceCtrl == 8'h00))
      else $error("bus reset did not clear ports");
   a_reset_irq_end: assert property (
      (inBusReset && !lineSe0) |=> pend[hub_port_pkg::PEND_BUSRST])
      else $error("bus reset interrupt missing");
   a_detect_bound: assert property (
      s_se0Long ##0 (se0Count == SE0_LIMIT) |-> ##[0:1] inBusReset)
      else $error("reset not detected in time");
   a_timer_tick: assert property (
      tick128 |=> pend[hub_port_pkg::PEND_T128])
      else $error("timer interrupt missing");
   a_babble_clear: assert property (
      (|babble) && !se0Hit |=> ((portEnable & $past(babble)) == 4'h0))
      else $error("babble did not disable port");
   // all ports at once, so any low speed port exercises the guard
   a_lowspeed_block: assert property (
      upFullSpeed |=> ((portRepeat & $past(portSpeed)) == 4'h0))
      else $error("full speed sent to low speed port");
   a_force_drive: assert property (
      (forceCtrl[1:0] == hub_port_pkg::FORCE_SE0) |=>
      (portDriveEn[0] && !portDriveDp[0] && !portDriveDm[0]))
      else $error("force field misdriven");
   a_ep_irq: assert property (
      epAck[0] |=> pend[hub_port_pkg::PEND_EP0])
      else $error("endpoint interrupt missing");
   a_enable_wait: assert property (
      (enableWanted[0] && packetActive && !portEnable[0] && !wrEn)
      |=> !portEnable[0])
      else $error("port enabled mid packet");
endmodule : usb_hub_port_control

//--- testbench/usb_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// upstream host and downstream devices seen by the hub
// ----------------------------------------------------------
module usb_far_end (
   input  wire logic       core_clk,
   input  wire logic       se0Req,
   input  wire logic       eofReq,
   input  wire logic [3:0] babbleReq,
   input  wire logic [3:0] openReq,
   output logic            upDp,
   output logic            upDm,
   output logic            eofTwo,
   output logic      [3:0] portNonIdle,
   output logic      [3:0] portOpen
);
   // host idles in full-speed J; a reset request pulls both lines low
   assign upDp = ~se0Req;
   assign upDm = 1'b0;
   // devices only chatter past EOF2 when a scenario asks them to
   assign portNonIdle = babbleReq;
   assign portOpen    = openReq;
   // frame marker is a one-cycle pulse, registered like the hub's timing
   always_ff @(posedge core_clk) begin
      eofTwo <= eofReq;
   end
endmodule : usb_far_end

//--- testbench/usb_hub_port_control_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// self-checking bench for the hub port control block
// ----------------------------------------------------------
module usb_hub_port_control_tb_top;
   localparam logic [7:0] aEn   = hub_port_pkg::ADDR_PORT_ENABLE;
   localparam logic [7:0] aSpd  = hub_port_pkg::ADDR_PORT_SPEED;
   localparam logic [7:0] aFrc  = hub_port_pkg::ADDR_FORCE_CTRL;
   localparam logic [7:0] aPend = hub_port_pkg::ADDR_INT_PEND;
   logic       core_clk, rst_b, regWrite, regRead, eofTwo, eofReq;
   logic       upDp, upDm, upFullSpeed, suspended, packetActive, se0Req;
   logic [7:0] regAddr, regWrData, regRdData, rd;
   logic [3:0] portConnect, portResume, portNonIdle, portOpen, babbleReq;
   logic [3:0] openReq, portRepeat, portDriveEn, portDriveDp;
   logic [3:0] portDriveDm, portSlowEdge;
   logic [4:0] epAck;
   logic [9:0] irqPending;
   int         failCount, samplesChecked;
   time        t0;

   usb_hub_port_control usb_hub_port_control_i (.core_clk(core_clk),
      .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .upDp(upDp), .upDm(upDm), .portConnect(portConnect),
      .portResume(portResume), .portNonIdle(portNonIdle),
      .portOpen(portOpen), .eofTwo(eofTwo), .packetActive(packetActive),
      .upFullSpeed(upFullSpeed), .suspended(suspended), .epAck(epAck),
      .portRepeat(portRepeat), .portDriveEn(portDriveEn),
      .portDriveDp(portDriveDp), .portDriveDm(portDriveDm),
      .portSlowEdge(portSlowEdge), .irqPending(irqPending));
   usb_far_end usb_far_end_i (.core_clk(core_clk), .se0Req(se0Req),
      .eofReq(eofReq), .babbleReq(babbleReq), .openReq(openReq),
      .upDp(upDp), .upDm(upDm), .eofTwo(eofTwo),
      .portNonIdle(portNonIdle), .portOpen(portOpen));

   // ----------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------
   task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
                  exp);
         failCount++;
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc
   // one-cycle write strobe, master never waits
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrite  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 rd = regRdData;
      chk(10'(rd), 10'(e));
   endtask : rdChk
   task automatic eof;
      @(posedge core_clk);
      eofReq <= 1'b1;
      @(posedge core_clk);
      eofReq <= 1'b0;
      cyc(3);
   endtask : eof
   task automatic endSim;
      $display("checks %0d mismatches %0d", samplesChecked, failCount);
      if (failCount == 0 && samplesChecked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : endSim

   // ----------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------
   // two successive flags one period apart give the full timer span, not the reset offset
   task automatic testTimer;
      for (int n = 0; n < 13000 && irqPending[1] !== 1'b1; n++) cyc(1);
      t0 = $time;
      wr(aPend, 8'h02);
      // the cleared flag reaches the output two edges after the strobe
      cyc(2);
      for (int n = 0; n < 13000 && irqPending[1] !== 1'b1; n++) cyc(1);
      chk(10'(($time - t0) >= 127950 && ($time - t0) <= 128050), 10'h1);
      chk(10'(irqPending[2]), 10'h0);
   endtask : testTimer
   task automatic testRegs;
      rdChk(aEn, 8'h00);
      rdChk(aSpd, 8'h00);
      rdChk(aFrc, 8'h00);
      chk(10'(portRepeat), 10'h0);
      // an unmapped place swallows writes and reads back zero
      wr(8'h7f, 8'ha5);
      rdChk(8'h7f, 8'h00);
      wr(aSpd, 8'hff);
      rdChk(aSpd, 8'h0f);
      chk(10'(portSlowEdge), 10'hf);
      wr(aSpd, 8'h05);
      rdChk(aSpd, 8'h05);
      chk(10'(portSlowEdge), 10'h5);
      wr(aSpd, 8'h00);
      // every force code on all ports, enables left clear meanwhile
      for (int c = 0; c < 4; c++) begin
         wr(aFrc, {4{2'(c)}});
         cyc(2);
         chk(10'(portDriveEn), (c != 0) ? 10'hf : 10'h0);
         if (c != 0)
            chk(10'({portDriveDp, portDriveDm}),
                10'({(c == 1) ? 4'hf : 4'h0, (c == 2) ? 4'hf : 4'h0}));
      end
      wr(aFrc, 8'h00);
      cyc(2);
      chk(10'(portDriveEn), 10'h0);
   endtask : testRegs
   task automatic testRepeat;
      packetActive <= 1'b1;
      wr(aEn, 8'h01);
      cyc(4);
      chk(10'(portRepeat), 10'h0);
      packetActive <= 1'b0;
      cyc(3);
      chk(10'(portRepeat), 10'h1);
      wr(aEn, 8'h03);
      cyc(3);
      chk(10'(portRepeat), 10'h3);
      wr(aSpd, 8'h02);
      upFullSpeed <= 1'b1;
      cyc(3);
      chk(10'(portRepeat), 10'h1);
      upFullSpeed <= 1'b0;
      // the port suspend register, not the chip suspend, stops repeating
      wr(hub_port_pkg::ADDR_SUSPEND, 8'h03);
      cyc(3);
      chk(10'(portRepeat), 10'h0);
      wr(hub_port_pkg::ADDR_SUSPEND, 8'h00);
      wr(aSpd, 8'h00);
   endtask : testRepeat
   task automatic testHub;
      wr(aPend, 8'hff);
      babbleReq <= 4'h5;
      eof();
      babbleReq <= 4'h0;
      rdChk(aEn, 8'h02);
      chk(10'(irqPending[3]), 10'h1);
      wr(aPend, 8'hff);
      openReq <= 4'h2;
      eof();
      openReq <= 4'h0;
      rdChk(aEn, 8'h00);
      chk(10'(irqPending[3]), 10'h1);
      wr(aPend, 8'hff);
      portResume <= 4'h4;
      cyc(6);
      chk(10'(irqPending[3]), 10'h0);
      portResume <= 4'h0;
      wr(aEn, 8'h04);
      cyc(4);
      portResume <= 4'h4;
      cyc(6);
      chk(10'(irqPending[3]), 10'h1);
      portResume <= 4'h0;
      wr(aEn, 8'h00);
      wr(aFrc, 8'h04);
      wr(aPend, 8'hff);
      portConnect <= 4'h2;
      cyc(6);
      chk(10'(irqPending[3]), 10'h0);
      wr(aFrc, 8'h00);
      portConnect <= 4'h6;
      cyc(6);
      chk(10'(irqPending[3]), 10'h1);
      wr(hub_port_pkg::ADDR_INT_ENABLE, 8'h00);
      wr(aPend, 8'hff);
      suspended   <= 1'b1;
      portConnect <= 4'h7;
      cyc(6);
      chk(10'(irqPending[3]), 10'h1);
      suspended <= 1'b0;
      chk(10'(irqPending[8:4]), 10'h0);
      for (int i = 0; i < 5; i++) begin
         epAck <= 5'(1 << i);
         cyc(1);
         epAck <= 5'h00;
         cyc(2);
         chk(10'(irqPending[4 + i]), 10'h1);
      end
   endtask : testHub
   // a short SE0 must leave state alone, a long one clears it
   task automatic testBusReset;
      logic [7:0] addr [5] = '{hub_port_pkg::ADDR_DEV_ADDR_A,
                               hub_port_pkg::ADDR_DEV_ADDR_B, aEn, aSpd, aFrc};
      logic [7:0] val  [5] = '{8'h05, 8'h06, 8'h0a, 8'h03, 8'h11};
      for (int i = 0; i < 5; i++) wr(addr[i], val[i]);
      se0Req <= 1'b1;
      cyc(1100);
      se0Req <= 1'b0;
      cyc(8);
      for (int i = 0; i < 5; i++) rdChk(addr[i], val[i]);
      chk(10'(irqPending[0]), 10'h0);
      se0Req <= 1'b1;
      cyc(1700);
      for (int i = 0; i < 5; i++) rdChk(addr[i], 8'h00);
      rdChk(hub_port_pkg::ADDR_STATUS, 8'h20);
      chk(10'(irqPending[0]), 10'h0);
      se0Req <= 1'b0;
      cyc(8);
      chk(10'(irqPending[0]), 10'h1);
   endtask : testBusReset

   // ----------------------------------------------------------
   // clock, watchdog and main sequence
   // ----------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // whole run is near 29k cycles; 40k means a hang
   initial begin
      repeat (40000) @(posedge core_clk);
      failCount++;
      endSim();
   end
   initial begin
      {rst_b, regWrite, regRead, eofReq, upFullSpeed} = '0;
      {suspended, packetActive, se0Req, regAddr, regWrData} = '0;
      {portConnect, portResume, babbleReq, openReq, epAck} = '0;
      failCount      = 0;
      samplesChecked = 0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      testTimer();
      testRegs();
      testRepeat();
      testHub();
      testBusReset();
      endSim();
   end
endmodule : usb_hub_port_control_tb_top
